/* rtl/rfcmd_pkg.sv */
// Constants and types shared by the block access command handler
package rfcmd_pkg;

  // ************************************************************
  // Command and response codes
  // ************************************************************
  localparam logic [7:0] CMD_READ = 8'h06;
  localparam logic [7:0] RSP_READ = 8'h07;
  localparam logic [7:0] CMD_WRITE = 8'h08;
  localparam logic [7:0] RSP_WRITE = 8'h09;

  // ************************************************************
  // Count limits
  // ************************************************************
  localparam logic [7:0] COUNT_MIN = 8'h01;
  localparam logic [7:0] READ_K_MAX = 8'h0F;
  localparam logic [7:0] READ_M_MAX = 8'h0F;
  localparam logic [7:0] WRITE_K_MAX = 8'h0B;
  localparam logic [7:0] WRITE_K_SPLIT = 8'h08;
  localparam logic [7:0] WRITE_M_MAX_LOW = 8'h0C;
  localparam logic [7:0] WRITE_M_MAX_HIGH = 8'h0B;
  localparam logic [7:0] VERIFY_M = 8'h01;

  // ************************************************************
  // Verify block list element, byte by byte
  // ************************************************************
  localparam logic [7:0] VERIFY_EL0 = 8'h00;
  localparam logic [7:0] VERIFY_EL1 = 8'h00;
  localparam logic [7:0] VERIFY_EL2 = 8'h01;
  localparam int ELEM_SHORT_BIT = 7;

  // ************************************************************
  // Frame layout
  // ************************************************************
  localparam int ID_BYTES = 8;
  localparam logic [7:0] ID_LAST = 8'h07;
  localparam logic [7:0] POS_ST1 = 8'h09;
  localparam logic [7:0] POS_ST2 = 8'h0A;
  localparam logic [7:0] POS_M = 8'h0B;
  localparam logic [7:0] POS_DATA = 8'h0C;

  // ************************************************************
  // Status flag values
  // ************************************************************
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_FAIL = 8'hFF;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_K = 8'hA1;
  localparam logic [7:0] ERR_M = 8'hA2;
  localparam logic [7:0] ERR_SID = 8'hA3;
  localparam logic [7:0] ERR_VERIFY = 8'hA4;

  // ************************************************************
  // State types
  // ************************************************************
  typedef enum logic [6:0] {
    F_ID = 7'b000_0001,
    F_K = 7'b000_0010,
    F_SID = 7'b000_0100,
    F_M = 7'b000_1000,
    F_BL = 7'b001_0000,
    F_DATA = 7'b010_0000,
    F_SKIP = 7'b100_0000
  } field_type;

  typedef enum logic [3:0] {
    M_RX = 4'b0001,
    M_TX = 4'b0010,
    M_FETCH = 4'b0100,
    M_LOAD = 4'b1000
  } main_type;

endpackage

/* rtl/byte_stream_if.sv */
// Valid and ready word stream between internal modules
`timescale 1ns/10ps
`default_nettype none
interface byte_stream_if #(parameter int WIDTH = 9) ();
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface
`default_nettype wire

/* rtl/byte_buffer.sv */
// Shift style buffer on the response path, head entry drives the outputs
`timescale 1ns/10ps
`default_nettype none
module byte_buffer #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  byte_stream_if.sink fill,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] slot [DEPTH];
  logic [WIDTH-1:0] next_slot [DEPTH];
  logic [DEPTH-1:0] full;
  logic [DEPTH-1:0] next_full;

  if (DEPTH < 2) begin : g_bad_depth
    $error("byte_buffer needs at least two entries");
  end

  // Room while the tail entry is free
  assign fill.ready = ~full[DEPTH-1];
  assign out_valid = full[0];
  assign out_data = slot[0];

  // Shift on pop, then place a push in the first free entry
  always_comb begin
    logic placed;
    placed = 1'b0;
    next_slot = slot;
    next_full = full;
    if (full[0] && out_ready) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_slot[i] = slot[i+1];
        next_full[i] = full[i+1];
      end
      next_full[DEPTH-1] = 1'b0;
    end
    if (fill.valid && fill.ready) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!placed && !next_full[i]) begin
          next_slot[i] = fill.data;
          next_full[i] = 1'b1;
          placed = 1'b1;
        end
      end
    end
  end

  // Entry registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      full <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        slot[i] <= '0;
      end
    end else begin
      full <= next_full;
      slot <= next_slot;
    end
  end

  // A stalled head word stays put
  hold_head_a: assert property (@(posedge clk) disable iff (!rst_n)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("head word changed while stalled");

endmodule
`default_nettype wire

/* rtl/count_limits.sv */
// Range checks on the service count and the block count
`timescale 1ns/10ps
`default_nettype none
module count_limits
  import rfcmd_pkg::*;
(
  input wire logic is_read,
  input wire logic [7:0] k,
  input wire logic [7:0] m,
  output logic k_ok,
  output logic m_ok
);

  logic [7:0] k_max;
  logic [7:0] m_max;

  // Limits depend on the command and, for writes, on the service count
  assign k_max = is_read ? READ_K_MAX : WRITE_K_MAX;
  assign m_max = is_read ? READ_M_MAX :
                 (k <= WRITE_K_SPLIT) ? WRITE_M_MAX_LOW : WRITE_M_MAX_HIGH;
  assign k_ok = (k >= COUNT_MIN) && (k <= k_max);
  assign m_ok = (m >= COUNT_MIN) && (m <= m_max);

endmodule
`default_nettype wire

/* rtl/rf_block_read_write_verify.sv */
// Block read, write and verify command handler for the contactless link
// Notes on behaviour
// - Read: code 0x06, 1 to 15 services
// - Read reply: 0x07, id, flags, count, data
// - Read failure drops count and data
// - Write data to memory or host port
// - Write frame: code, id, services, list, data
// - Frame carries identifier from polling
// - Write or verify: 1 to 11 services
// - Block limit 12, or 11 above eight services
// - Service values ignored but must match
// - Write reply: 0x09, id, two flags
// - List 0x000001 with one block means verify
// - Verify needs exactly one block
// - Any common service value accepted
`timescale 1ns/10ps
`default_nettype none
module rf_block_read_write_verify
  import rfcmd_pkg::*;
#(
  parameter int MAX_BLOCKS = 15,
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [63:0] card_id,
  input wire logic tunnel_mode,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_first,
  input wire logic rx_last,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic acc_we,
  output logic acc_re,
  output logic acc_host,
  output logic acc_verify,
  output logic [7:0] acc_block,
  output logic [3:0] acc_index,
  output logic [7:0] acc_wdata,
  input wire logic [7:0] acc_rdata
);

  if (MAX_BLOCKS != 15) begin : g_bad_blocks
    $error("block list storage must hold exactly 15 entries");
  end

  // ************************************************************
  // State
  // ************************************************************
  main_type state, next_state;
  field_type field, next_field;
  logic [7:0] cnt, next_cnt;
  logic cmd_read, next_cmd_read;
  logic [7:0] k, next_k;
  logic [7:0] m, next_m;
  logic [15:0] sid_first, next_sid_first;
  logic id_bad, next_id_bad;
  logic done, next_done;
  logic [7:0] err, next_err;
  logic is_verify, next_is_verify;
  logic [7:0] el0, next_el0;
  logic [7:0] el1, next_el1;
  logic [1:0] el_pos, next_el_pos;
  logic [3:0] el_cnt, next_el_cnt;
  logic [7:0] blk_list [MAX_BLOCKS];
  logic [7:0] next_blk_list [MAX_BLOCKS];
  logic [7:0] pos, next_pos;
  logic [7:0] read_byte, next_read_byte;
  logic tunnel, next_tunnel;
  logic next_rx_ready;
  logic next_acc_we, next_acc_re, next_acc_host, next_acc_verify;
  logic [7:0] next_acc_block, next_acc_wdata;
  logic [3:0] next_acc_index;

  logic take;
  logic k_ok, m_ok;
  logic [7:0] last_pos;
  logic [7:0] rsp_byte;

  byte_stream_if #(.WIDTH(9)) push ();

  // Identifier byte, most significant first
  function automatic logic [7:0] id_byte(input logic [63:0] id, input logic [7:0] idx);
    return id[(ID_BYTES - 1 - int'(idx[2:0])) * 8 +: 8];
  endfunction

  // ************************************************************
  // Count checks and response path
  // ************************************************************
  count_limits u_limits (
    .is_read(cmd_read),
    .k(field == F_K ? rx_data : k),
    .m(rx_data),
    .k_ok(k_ok),
    .m_ok(m_ok)
  );

  byte_buffer #(.WIDTH(9), .DEPTH(BUF_DEPTH)) u_buffer (
    .clk(clk),
    .rst_n(rst_n),
    .fill(push.sink),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data({tx_last, tx_data})
  );

  assign take = rx_valid && rx_ready;
  // Failed reads end after the flags
  assign last_pos = (cmd_read && err == ERR_NONE) ?
                    8'(POS_M + {m[3:0], 4'h0}) : POS_ST2;

  // Response byte for the current position
  always_comb begin
    if (pos == 8'h00) begin
      rsp_byte = cmd_read ? RSP_READ : RSP_WRITE;
    end else if (pos <= ID_LAST + 8'h01) begin
      rsp_byte = id_byte(card_id, 8'(pos - 8'h01));
    end else if (pos == POS_ST1) begin
      rsp_byte = (err == ERR_NONE) ? ST_OK : ST_FAIL;
    end else if (pos == POS_ST2) begin
      rsp_byte = err;
    end else if (pos == POS_M) begin
      rsp_byte = m;
    end else begin
      rsp_byte = read_byte;
    end
  end

  assign push.valid = (state == M_TX);
  assign push.data = {pos == last_pos, rsp_byte};

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic [7:0] noff;
    noff = 8'h00;
    next_state = state;
    next_field = field;
    next_cnt = cnt;
    next_cmd_read = cmd_read;
    next_k = k;
    next_m = m;
    next_sid_first = sid_first;
    next_id_bad = id_bad;
    next_done = done;
    next_err = err;
    next_is_verify = is_verify;
    next_el0 = el0;
    next_el1 = el1;
    next_el_pos = el_pos;
    next_el_cnt = el_cnt;
    next_blk_list = blk_list;
    next_pos = pos;
    next_read_byte = read_byte;
    next_tunnel = tunnel;
    next_rx_ready = rx_ready;
    next_acc_we = 1'b0;
    next_acc_re = 1'b0;
    next_acc_host = acc_host;
    next_acc_verify = acc_verify;
    next_acc_block = acc_block;
    next_acc_index = acc_index;
    next_acc_wdata = acc_wdata;
    unique case (state)
      M_RX: begin
        if (take && rx_first) begin
          // Command code opens a new frame
          next_cmd_read = (rx_data == CMD_READ);
          next_field = (rx_data == CMD_READ || rx_data == CMD_WRITE) ? F_ID : F_SKIP;
          next_cnt = 8'h00;
          next_err = ERR_NONE;
          next_id_bad = 1'b0;
          next_done = 1'b0;
          next_is_verify = 1'b0;
          next_el_pos = 2'd0;
          next_el_cnt = 4'd0;
          next_tunnel = tunnel_mode;
        end else if (take) begin
          unique case (field)
            F_ID: begin
              if (rx_data != id_byte(card_id, cnt)) begin
                next_id_bad = 1'b1;
              end
              next_cnt = 8'(cnt + 8'h01);
              if (cnt == ID_LAST) begin
                next_field = F_K;
                next_cnt = 8'h00;
              end
            end
            F_K: begin
              next_k = rx_data;
              if (!k_ok) begin
                next_err = ERR_K;
                next_done = 1'b1;
                next_field = F_SKIP;
              end else begin
                next_field = F_SID;
              end
            end
            F_SID: begin
              // First value kept, the rest must equal it
              if (cnt < 8'h02) begin
                next_sid_first[cnt[0] ? 0 : 8 +: 8] = rx_data;
              end else if (rx_data != sid_first[cnt[0] ? 0 : 8 +: 8]) begin
                next_err = ERR_SID;
                next_done = 1'b1;
                next_field = F_SKIP;
              end
              next_cnt = 8'(cnt + 8'h01);
              if (next_field == F_SID && 9'(cnt) + 9'd1 == {k, 1'b0}) begin
                next_field = F_M;
              end
            end
            F_M: begin
              next_m = rx_data;
              if (!m_ok) begin
                next_err = ERR_M;
                next_done = 1'b1;
                next_field = F_SKIP;
              end else begin
                next_field = F_BL;
              end
            end
            F_BL: begin
              next_el_pos = 2'(el_pos + 2'd1);
              if (el_pos == 2'd0) begin
                next_el0 = rx_data;
              end else if (el_pos == 2'd1) begin
                next_el1 = rx_data;
              end
              if ((el_pos == 2'd1 && el0[ELEM_SHORT_BIT]) || el_pos == 2'd2) begin
                // Element complete, low block byte kept
                next_blk_list[el_cnt] = (el_pos == 2'd1) ? rx_data : el1;
                next_el_pos = 2'd0;
                next_el_cnt = 4'(el_cnt + 4'd1);
                if (!cmd_read && el_cnt == 4'd0 && el_pos == 2'd2 && el0 == VERIFY_EL0
                    && el1 == VERIFY_EL1 && rx_data == VERIFY_EL2) begin
                  next_is_verify = 1'b1;
                end
                if (next_is_verify && m != VERIFY_M) begin
                  next_err = ERR_VERIFY;
                  next_done = 1'b1;
                  next_field = F_SKIP;
                end else if ({4'h0, el_cnt} + 8'h01 == m) begin
                  next_done = cmd_read;
                  next_field = cmd_read ? F_SKIP : F_DATA;
                  next_cnt = 8'h00;
                end
              end
            end
            F_DATA: begin
              // Data only reaches memory for a clean frame
              next_acc_we = (err == ERR_NONE);
              next_acc_host = tunnel;
              next_acc_verify = is_verify;
              next_acc_block = blk_list[cnt[7:4]];
              next_acc_index = cnt[3:0];
              next_acc_wdata = rx_data;
              next_cnt = 8'(cnt + 8'h01);
              if (cnt + 8'h01 == {m[3:0], 4'h0}) begin
                next_done = 1'b1;
                next_field = F_SKIP;
              end
            end
            F_SKIP: begin
              next_field = F_SKIP;
            end
            default: begin
              next_field = F_SKIP;
            end
          endcase
        end
        if (take && rx_last) begin
          // Reply only to complete frames meant for this card
          next_field = F_SKIP;
          next_pos = 8'h00;
          if (next_done && !next_id_bad) begin
            next_state = M_TX;
            next_rx_ready = 1'b0;
          end
        end
      end
      M_TX: begin
        if (push.ready) begin
          next_pos = 8'(pos + 8'h01);
          noff = 8'(pos + 8'h01 - POS_DATA);
          if (pos == last_pos) begin
            next_state = M_RX;
            next_rx_ready = 1'b1;
          end else if (pos + 8'h01 >= POS_DATA) begin
            // Fetch the next read byte
            next_state = M_FETCH;
            next_acc_re = 1'b1;
            next_acc_host = tunnel;
            next_acc_verify = 1'b0;
            next_acc_block = blk_list[noff[7:4]];
            next_acc_index = noff[3:0];
          end
        end
      end
      M_FETCH: begin
        next_state = M_LOAD;
      end
      M_LOAD: begin
        next_read_byte = acc_rdata;
        next_state = M_TX;
      end
      default: begin
        next_state = M_RX;
        next_rx_ready = 1'b1;
      end
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= M_RX;
      field <= F_SKIP;
      cnt <= 8'h00;
      cmd_read <= 1'b0;
      k <= 8'h00;
      m <= 8'h00;
      sid_first <= 16'h0000;
      id_bad <= 1'b0;
      done <= 1'b0;
      err <= ERR_NONE;
      is_verify <= 1'b0;
      el0 <= 8'h00;
      el1 <= 8'h00;
      el_pos <= 2'd0;
      el_cnt <= 4'd0;
      for (int i = 0; i < MAX_BLOCKS; i++) begin
        blk_list[i] <= 8'h00;
      end
      pos <= 8'h00;
      read_byte <= 8'h00;
      tunnel <= 1'b0;
      rx_ready <= 1'b1;
      acc_we <= 1'b0;
      acc_re <= 1'b0;
      acc_host <= 1'b0;
      acc_verify <= 1'b0;
      acc_block <= 8'h00;
      acc_index <= 4'h0;
      acc_wdata <= 8'h00;
    end else begin
      state <= next_state;
      field <= next_field;
      cnt <= next_cnt;
      cmd_read <= next_cmd_read;
      k <= next_k;
      m <= next_m;
      sid_first <= next_sid_first;
      id_bad <= next_id_bad;
      done <= next_done;
      err <= next_err;
      is_verify <= next_is_verify;
      el0 <= next_el0;
      el1 <= next_el1;
      el_pos <= next_el_pos;
      el_cnt <= next_el_cnt;
      blk_list <= next_blk_list;
      pos <= next_pos;
      read_byte <= next_read_byte;
      tunnel <= next_tunnel;
      rx_ready <= next_rx_ready;
      acc_we <= next_acc_we;
      acc_re <= next_acc_re;
      acc_host <= next_acc_host;
      acc_verify <= next_acc_verify;
      acc_block <= next_acc_block;
      acc_index <= next_acc_index;
      acc_wdata <= next_acc_wdata;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence fetch_s;
    state == M_FETCH && acc_re ##1 state == M_LOAD ##1 state == M_TX;
  endsequence

  read_code_a: assert property (push.valid && pos == 8'h00 && cmd_read
    |-> push.data[7:0] == RSP_READ) else $error("bad read reply code");
  count_echo_a: assert property (push.valid && pos == POS_M
    |-> push.data[7:0] == m) else $error("block count not echoed");
  short_fail_a: assert property (push.valid && push.ready && pos == POS_ST2 && err != ERR_NONE
    |-> push.data[8] ##1 state == M_RX) else $error("failed reply too long");
  write_code_a: assert property (push.valid && pos == 8'h00 && !cmd_read
    |-> push.data[7:0] == RSP_WRITE && last_pos == POS_ST2)
    else $error("bad write reply");
  store_data_a: assert property (take && !rx_first && field == F_DATA
    |=> acc_we && acc_wdata == $past(rx_data)) else $error("write byte lost");
  clean_write_a: assert property (acc_we |-> err == ERR_NONE)
    else $error("write after error");
  read_k_a: assert property (take && !rx_first && field == F_K && cmd_read
    && (rx_data == 8'h00 || rx_data > READ_K_MAX) |=> err == ERR_K)
    else $error("read count not refused");
  write_k_a: assert property (take && !rx_first && field == F_K && !cmd_read
    && (rx_data == 8'h00 || rx_data > WRITE_K_MAX) |=> err == ERR_K)
    else $error("write count not refused");
  write_m_a: assert property (take && !rx_first && field == F_M && !cmd_read
    && k > WRITE_K_SPLIT && rx_data == WRITE_M_MAX_LOW |=> err == ERR_M)
    else $error("block limit not applied");
  sid_same_a: assert property (take && !rx_first && field == F_SID && cnt >= 8'h02
    && rx_data != sid_first[cnt[0] ? 0 : 8 +: 8] |=> err == ERR_SID && field == F_SKIP)
    else $error("service mismatch missed");
  verify_one_a: assert property (is_verify && field == F_DATA |-> m == VERIFY_M)
    else $error("verify with many blocks");
  data_fetch_a: assert property (state == M_TX && push.ready && pos != last_pos
    && pos + 8'h01 >= POS_DATA |=> fetch_s) else $error("read fetch broken");

endmodule
`default_nettype wire

/* sim/reader_model.sv */
// Reader side model that sends command frames and takes reply frames
`timescale 1ns/10ps
`default_nettype none
module reader_model (
  input wire logic clk,
  input wire logic rx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_first,
  output logic rx_last,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_last
);
  // ************************************************************
  // Frame transfer
  // ************************************************************
  // Idle values at time zero
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_first = 1'b0;
    rx_last = 1'b0;
    tx_ready = 1'b1;
  end
  // Each byte holds until taken, idle data shows the inverse of the last
  task automatic send(input logic [7:0] q[$]);
    for (int i = 0; i < q.size(); i++) begin
      rx_valid <= 1'b1;
      rx_data <= q[i];
      rx_first <= (i == 0);
      rx_last <= (i == q.size() - 1);
      @(posedge clk);
      while (rx_ready !== 1'b1) @(posedge clk);
    end
    rx_valid <= 1'b0;
    rx_data <= ~q[q.size() - 1];
  endtask
  // Takes reply bytes, stalling every other cycle when slow
  task automatic recv(input bit slow, output logic [7:0] r[$]);
    r = {};
    for (int n = 0; n < 400; n++) begin
      @(posedge clk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        r.push_back(tx_data);
        if (tx_last === 1'b1) break;
      end
      // Ready ends high once the wait runs out
      tx_ready <= (slow && n < 399) ? ~tx_ready : 1'b1;
    end
  endtask
endmodule
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the block access command handler
`timescale 1ns/10ps
`default_nettype none
module tb;
  import rfcmd_pkg::*;
  // ************************************************************
  // Signals and instances
  // ************************************************************
  localparam logic [63:0] own_id = 64'h1122_3344_5566_7788; // Arbitrary value
  logic clk, rst_n, tunnel_mode, rx_valid, rx_ready, rx_first, rx_last;
  logic tx_valid, tx_ready, tx_last, acc_we, acc_re, acc_host, acc_verify, whost, wver;
  logic [7:0] rx_data, tx_data, acc_block, acc_wdata, wblk;
  logic [7:0] acc_rdata = 8'h00;
  logic [3:0] acc_index;
  logic [15:0] wsum;
  logic [7:0] q[$];
  logic [7:0] r[$];
  int err_count = 0;
  int num_checks = 0;
  int wcount;
  rf_block_read_write_verify i_dut (.clk(clk), .rst_n(rst_n), .card_id(own_id),
    .tunnel_mode(tunnel_mode), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .rx_first(rx_first), .rx_last(rx_last), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_last(tx_last), .acc_we(acc_we), .acc_re(acc_re),
    .acc_host(acc_host), .acc_verify(acc_verify), .acc_block(acc_block),
    .acc_index(acc_index), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata));
  reader_model i_rdr (.clk(clk), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_first(rx_first), .rx_last(rx_last), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_last(tx_last));
  // Clock at 25 ns
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Memory answers one cycle after a read, writes are tallied
  always @(posedge clk) begin
    acc_rdata <= (acc_re === 1'b1) ? (acc_block ^ {acc_index, 4'h0}) : ~acc_rdata;
    if (acc_we === 1'b1) begin
      wcount++;
      wsum = wsum + 16'(acc_wdata);
      wblk = acc_block;
      whost = acc_host;
      wver = acc_verify;
    end
  end
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic cmp(input string name, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask
  // Builds one command frame into q
  task automatic mk(input logic [7:0] code, k, m, input bit diff, el3, input int nd);
    q = {code};
    for (int i = 0; i < 8; i++) q.push_back(own_id[63-8*i -: 8]);
    q.push_back(k);
    for (int i = 0; i < k; i++) q = {q, 8'h09, (diff && i == 1) ? 8'h01 : 8'h00};
    q.push_back(m);
    for (int i = 0; i < m; i++) begin
      if (el3) q = {q, VERIFY_EL0, VERIFY_EL1, VERIFY_EL2};
      else q = {q, 8'h80, 8'h03 + i[7:0]};
    end
    for (int i = 0; i < nd; i++) q.push_back(8'h40 + i[7:0]);
  endtask
  task automatic xact(input logic t, input bit slow);
    tunnel_mode <= t;
    wcount = 0;
    wsum = 16'h0000;
    wver = 1'b0;
    i_rdr.send(q);
    i_rdr.recv(slow, r);
  endtask
  task automatic chk(input logic [7:0] code, input int len, input logic [7:0] s1, s2);
    cmp("reply length", len[15:0], r.size());
    cmp("reply code", code, r[0]);
    for (int i = 0; i < 8; i++) cmp("reply id", own_id[63-8*i -: 8], r[1+i]);
    cmp("status one", s1, r[9]);
    cmp("status two", s2, r[10]);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_read();
    mk(CMD_READ, 8'h01, 8'h01, 0, 0, 0);
    xact(0, 1);
    chk(RSP_READ, 28, ST_OK, ERR_NONE);
    cmp("block count", 16'h0001, r[11]);
    for (int i = 0; i < 16; i++) cmp("read data", 8'h03 ^ {i[3:0], 4'h0}, r[12+i]);
  endtask
  task automatic t_read_err();
    mk(CMD_READ, 8'h10, 8'h01, 0, 0, 0);
    xact(0, 0);
    chk(RSP_READ, 11, ST_FAIL, ERR_K);
  endtask
  task automatic t_write_max();
    mk(CMD_WRITE, 8'h08, 8'h0C, 0, 0, 192);
    xact(1, 1);
    chk(RSP_WRITE, 11, ST_OK, ERR_NONE);
    cmp("write count", 16'd192, wcount[15:0]);
    cmp("write sum", 16'h77A0, wsum);
    cmp("last block", 16'h000E, wblk);
    cmp("host target", 16'h0001, whost);
  endtask
  task automatic t_errs();
    logic [7:0] ks[4] = '{8'h00, 8'h0C, 8'h09, 8'h02};
    logic [7:0] ms[4] = '{8'h01, 8'h01, 8'h0C, 8'h01};
    logic [7:0] es[4] = '{ERR_K, ERR_K, ERR_M, ERR_SID};
    for (int i = 0; i < 4; i++) begin
      mk(CMD_WRITE, ks[i], ms[i], i == 3, 0, 16 * ms[i]);
      xact(0, 0);
      chk(RSP_WRITE, 11, ST_FAIL, es[i]);
      cmp("error writes", 16'h0000, wcount[15:0]);
    end
  endtask
  task automatic t_verify();
    mk(CMD_WRITE, 8'h01, 8'h01, 0, 1, 16);
    xact(0, 0);
    chk(RSP_WRITE, 11, ST_OK, ERR_NONE);
    cmp("verify flag", 16'h0001, wver);
    cmp("verify count", 16'd16, wcount[15:0]);
    cmp("memory target", 16'h0000, whost);
    mk(CMD_WRITE, 8'h01, 8'h02, 0, 1, 32);
    xact(0, 1);
    chk(RSP_WRITE, 11, ST_FAIL, ERR_VERIFY);
    cmp("verify writes", 16'h0000, wcount[15:0]);
  endtask
  task automatic t_bad_id();
    mk(CMD_READ, 8'h01, 8'h01, 0, 0, 0);
    q[3] = ~q[3];
    xact(0, 0);
    cmp("silent length", 16'h0000, r.size());
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Reset, then the scenarios in turn
  initial begin
    rst_n = 1'b0;
    tunnel_mode = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_read();
    t_read_err();
    t_write_max();
    t_errs();
    t_verify();
    t_bad_id();
    report_and_stop();
  end
  // Watchdog against a hang
  initial begin
    #500000;
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
